// ### utf_pkg.sv
package utf_pkg;
   localparam int unsigned TX_DEPTH          = 64;
   localparam int unsigned LVL_W             = 7;
   localparam int unsigned PTR_W             = 6;
   // Control register field positions
   localparam int unsigned CTRL_EN_BIT       = 0;
   localparam int unsigned CTRL_RXCLR_BIT    = 1;
   localparam int unsigned CTRL_TXCLR_BIT    = 2;
   localparam int unsigned CTRL_TXTRIG_LSB   = 4;
   localparam int unsigned CTRL_RXTRIG_LSB   = 6;
   localparam logic [7:0]  CTRL_RESET        = 8'h00;
   // Trigger levels
   localparam logic [6:0]  RX_TRIG_0         = 7'd8;
   localparam logic [6:0]  RX_TRIG_1         = 7'd16;
   localparam logic [6:0]  RX_TRIG_2         = 7'd56;
   localparam logic [6:0]  RX_TRIG_3         = 7'd60;
   localparam logic [6:0]  TX_TRIG_0         = 7'd8;
   localparam logic [6:0]  TX_TRIG_1         = 7'd16;
   localparam logic [6:0]  TX_TRIG_2         = 7'd32;
   localparam logic [6:0]  TX_TRIG_3         = 7'd56;
   // Clear lasts at least two reference clocks
   localparam int unsigned CLR_MIN_CLKS      = 2;
   localparam logic [1:0]  CLR_CYCLES        = 2'(CLR_MIN_CLKS);
   // Bit time in reference clocks
   localparam logic [15:0] BIT_CYCLES_RESET  = 16'h0010;

   typedef struct packed {
      logic [1:0] rx_trig;
      logic [1:0] tx_trig;
      logic       tx_clr;
      logic       rx_clr;
      logic       fifo_en;
   } utf_ctrl_t;

   typedef enum logic [1:0] {
      SH_IDLE  = 2'b00,
      SH_START = 2'b01,
      SH_DATA  = 2'b10,
      SH_STOP  = 2'b11
   } utf_sh_state_t;
endpackage

// ### utf_tx_shifter.sv
`timescale 1ns/1ps
module utf_tx_shifter
   import utf_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // Byte in
   input  wire logic        load_valid_i,
   input  wire logic [7:0]  load_data_i,
   output logic             load_ready_o,
   // Serial out
   input  wire logic [15:0] bit_cycles_i,
   output logic             tx_o,
   output logic             busy_o
);
   import utf_pkg::*;

   utf_sh_state_t state;
   logic [7:0]    shift;
   logic [2:0]    bit_idx;
   logic [15:0]   cnt;
   logic          bit_end;

   assign bit_end      = (cnt == 16'h0000);
   assign load_ready_o = (state == SH_IDLE);
   assign busy_o       = (state != SH_IDLE);

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state   <= SH_IDLE;
         shift   <= 8'h00;
         bit_idx <= 3'd0;
         cnt     <= 16'h0000;
         tx_o    <= 1'b1;
      end
      else
      begin
         cnt <= bit_end ? bit_cycles_i - 16'h0001 : cnt - 16'h0001;
         unique case (state)
            SH_IDLE:
            begin
               tx_o <= 1'b1;
               if (load_valid_i)
               begin
                  shift <= load_data_i;
                  state <= SH_START;
                  tx_o  <= 1'b0;
                  cnt   <= bit_cycles_i - 16'h0001;
               end
            end
            SH_START:
               if (bit_end)
               begin
                  tx_o    <= shift[0];
                  shift   <= {1'b0, shift[7:1]};
                  bit_idx <= 3'd0;
                  state   <= SH_DATA;
               end
            SH_DATA:
               if (bit_end)
               begin
                  if (bit_idx == 3'd7)
                  begin
                     tx_o  <= 1'b1;
                     state <= SH_STOP;
                  end
                  else
                  begin
                     tx_o    <= shift[0];
                     shift   <= {1'b0, shift[7:1]};
                     bit_idx <= bit_idx + 3'd1;
                  end
               end
            SH_STOP:
               if (bit_end)
                  state <= SH_IDLE;
         endcase
      end
   end
endmodule // utf_tx_shifter

// ### utf_tx_fifo_ctrl.sv
`timescale 1ns/1ps
module utf_tx_fifo_ctrl
   import utf_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // Control register write port
   input  wire logic        ctrl_wr_i,
   input  wire logic [7:0]  ctrl_wdata_i,
   input  wire logic        enh_en_i,
   // Transmit data write port
   input  wire logic        tx_wr_i,
   input  wire logic [7:0]  tx_wdata_i,
   // Receive side hooks
   input  wire logic [6:0]  rx_level_i,
   output logic             rx_clear_o,
   // Settings and status
   output utf_pkg::utf_ctrl_t ctrl_o,
   output logic [6:0]       tx_level_o,
   output logic [6:0]       tx_space_o,
   output logic             tx_full_o,
   output logic             tx_empty_o,
   output logic             tx_overflow_o,
   output logic             tx_trig_o,
   output logic             rx_trig_o,
   output logic             tx_idle_o,
   // Serial line
   input  wire logic [15:0] bit_cycles_i,
   output logic             tx_o
);
   import utf_pkg::*;

   // Trigger level decode, one table for each flag
   function automatic logic [6:0] rx_trig_lvl(input logic [1:0] sel);
      unique case (sel)
         2'b00: rx_trig_lvl = RX_TRIG_0;
         2'b01: rx_trig_lvl = RX_TRIG_1;
         2'b10: rx_trig_lvl = RX_TRIG_2;
         2'b11: rx_trig_lvl = RX_TRIG_3;
      endcase
   endfunction

   function automatic logic [6:0] tx_trig_lvl(input logic [1:0] sel);
      unique case (sel)
         2'b00: tx_trig_lvl = TX_TRIG_0;
         2'b01: tx_trig_lvl = TX_TRIG_1;
         2'b10: tx_trig_lvl = TX_TRIG_2;
         2'b11: tx_trig_lvl = TX_TRIG_3;
      endcase
   endfunction

   // Store, pointers and settings
   logic [7:0]       mem [TX_DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [LVL_W-1:0] level;
   logic [LVL_W-1:0] next_level;
   logic             fifo_en;
   logic [1:0]       rx_trig_sel;
   logic [1:0]       tx_trig_sel;
   logic             tx_clr;
   logic             rx_clr;
   logic [1:0]       tx_clr_cnt;
   logic [1:0]       rx_clr_cnt;
   logic             push;
   logic             pop;
   logic             sh_ready;
   logic             sh_busy;
   logic             clr_req_tx;
   logic             clr_req_rx;

   // Clear requests are taken from the write strobe itself
   assign clr_req_tx = ctrl_wr_i && ctrl_wdata_i[CTRL_TXCLR_BIT];
   assign clr_req_rx = ctrl_wr_i && ctrl_wdata_i[CTRL_RXCLR_BIT];

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         fifo_en     <= CTRL_RESET[CTRL_EN_BIT];
         rx_trig_sel <= CTRL_RESET[CTRL_RXTRIG_LSB +: 2];
         tx_trig_sel <= CTRL_RESET[CTRL_TXTRIG_LSB +: 2];
      end
      else if (ctrl_wr_i)
      begin
         fifo_en     <= ctrl_wdata_i[CTRL_EN_BIT];
         rx_trig_sel <= ctrl_wdata_i[CTRL_RXTRIG_LSB +: 2];
         if (enh_en_i)
            tx_trig_sel <= ctrl_wdata_i[CTRL_TXTRIG_LSB +: 2];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         tx_clr     <= 1'b0;
         tx_clr_cnt <= 2'd0;
      end
      else if (clr_req_tx)
      begin
         tx_clr     <= 1'b1;
         tx_clr_cnt <= CLR_CYCLES - 2'd1;
      end
      else if (tx_clr)
      begin
         if (tx_clr_cnt == 2'd0)
            tx_clr <= 1'b0;
         else
            tx_clr_cnt <= tx_clr_cnt - 2'd1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         rx_clr     <= 1'b0;
         rx_clr_cnt <= 2'd0;
      end
      else if (clr_req_rx)
      begin
         rx_clr     <= 1'b1;
         rx_clr_cnt <= CLR_CYCLES - 2'd1;
      end
      else if (rx_clr)
      begin
         if (rx_clr_cnt == 2'd0)
            rx_clr <= 1'b0;
         else
            rx_clr_cnt <= rx_clr_cnt - 2'd1;
      end
   end

   assign push = tx_wr_i && (level != LVL_W'(TX_DEPTH)) && !tx_clr;
   assign pop  = sh_ready && (level != '0) && !tx_clr;

   // Level after this cycle's push and pop
   always_comb
   begin
      next_level = level;
      if (push)
         next_level = next_level + LVL_W'(1);
      if (pop)
         next_level = next_level - LVL_W'(1);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (push)
         mem[wr_ptr] <= tx_wdata_i;
   end

   // Pointers and level; a clear empties the store but spares the shifter
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i || tx_clr)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + PTR_W'(1);
         if (pop)
            rd_ptr <= rd_ptr + PTR_W'(1);
         level <= next_level;
      end
   end

   // Sticky until a transmit clear; a new drop wins over the clear
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         tx_overflow_o <= 1'b0;
      else if (tx_wr_i && (level == LVL_W'(TX_DEPTH)))
         tx_overflow_o <= 1'b1;
      else if (clr_req_tx)
         tx_overflow_o <= 1'b0;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         tx_trig_o <= 1'b0;
      else
         tx_trig_o <= fifo_en && enh_en_i
                      && ((LVL_W'(TX_DEPTH) - level) >= tx_trig_lvl(tx_trig_sel));
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         rx_trig_o <= 1'b0;
      else
         rx_trig_o <= fifo_en && (rx_level_i >= rx_trig_lvl(rx_trig_sel));
   end

   utf_tx_shifter u_shifter (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .load_valid_i (pop),
      .load_data_i  (mem[rd_ptr]),
      .load_ready_o (sh_ready),
      .bit_cycles_i (bit_cycles_i),
      .tx_o         (tx_o),
      .busy_o       (sh_busy)
   );

   // Settings as seen by the rest of the UART
   always_comb
   begin
      ctrl_o         = '0;
      ctrl_o.rx_trig = rx_trig_sel;
      ctrl_o.tx_trig = tx_trig_sel;
      ctrl_o.tx_clr  = tx_clr;
      ctrl_o.rx_clr  = rx_clr;
      ctrl_o.fifo_en = fifo_en;
   end

   // Status from the level; rx_clear_o follows rx_clr and tx_idle_o also needs the shifter idle
   assign rx_clear_o = rx_clr;
   assign tx_level_o = level;
   assign tx_space_o = LVL_W'(TX_DEPTH) - level;
   assign tx_full_o  = (level == LVL_W'(TX_DEPTH));
   assign tx_empty_o = (level == '0);
   assign tx_idle_o  = !sh_busy && (level == '0);
endmodule // utf_tx_fifo_ctrl

// ### utf_tx_fifo_ctrl_asserts.sv
`timescale 1ns/1ps
module utf_tx_fifo_ctrl_chk
   import utf_pkg::*;
(
   // Clock, reset and host writes
   input  wire logic               ref_clk_i,
   input  wire logic               rst_i,
   input  wire logic               ctrl_wr_i,
   input  wire logic [7:0]         ctrl_wdata_i,
   input  wire logic               enh_en_i,
   input  wire logic               tx_wr_i,
   // Design outputs
   input  wire logic               rx_clear_o,
   input  wire utf_pkg::utf_ctrl_t ctrl_o,
   input  wire logic [6:0]         tx_level_o,
   input  wire logic [6:0]         tx_space_o,
   input  wire logic               tx_full_o,
   input  wire logic               tx_empty_o,
   input  wire logic               tx_overflow_o,
   input  wire logic               tx_trig_o,
   input  wire logic               rx_trig_o,
   input  wire logic               tx_idle_o,
   input  wire logic               tx_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   reset_clean_a: assert property ($fell(rst_i) |-> ctrl_o == 7'h00 && tx_empty_o && tx_o)
      else $error("state not clean after reset");
   txclr_pulse_a: assert property (ctrl_wr_i && ctrl_wdata_i[2] |=> ctrl_o.tx_clr [*2] ##1 !ctrl_o.tx_clr)
      else $error("tx clear not two cycles");
   rxclr_pulse_a: assert property (ctrl_wr_i && ctrl_wdata_i[1] |=> rx_clear_o [*2] ##1 !rx_clear_o)
      else $error("rx clear not two cycles");
   txclr_empty_a: assert property (ctrl_wr_i && ctrl_wdata_i[2] |=> ##1 tx_empty_o && tx_level_o == 7'h00)
      else $error("store not emptied by clear");
   full_drop_a: assert property (tx_wr_i && tx_full_o |=> tx_overflow_o)
      else $error("write while full not flagged");
   space_sum_a: assert property (tx_level_o <= 7'h40 && tx_space_o + tx_level_o == 7'h40)
      else $error("level and space disagree");
   trig_keep_a: assert property (ctrl_wr_i && !enh_en_i |=> $stable(ctrl_o.tx_trig))
      else $error("tx trigger changed without enhanced enable");
   txtrig_set_a: assert property (ctrl_wr_i && enh_en_i |=> ctrl_o.tx_trig == $past(ctrl_wdata_i[5:4]))
      else $error("tx trigger field not taken");
   rxtrig_set_a: assert property (ctrl_wr_i |=> ctrl_o.rx_trig == $past(ctrl_wdata_i[7:6])
      && ctrl_o.fifo_en == $past(ctrl_wdata_i[0]))
      else $error("rx trigger or enable not taken");
   trig_off_a: assert property (!ctrl_o.fifo_en && $past(!ctrl_o.fifo_en) |-> !tx_trig_o && !rx_trig_o)
      else $error("trigger flagged while disabled");
   line_idle_a: assert property (tx_idle_o |-> tx_o)
      else $error("line not high while idle");

   cover property (tx_wr_i && tx_full_o);
   cover property (ctrl_o.tx_clr);
   cover property (tx_trig_o && rx_trig_o);
endmodule // utf_tx_fifo_ctrl_chk

bind utf_tx_fifo_ctrl utf_tx_fifo_ctrl_chk chk_u (.ref_clk_i, .rst_i, .ctrl_wr_i, .ctrl_wdata_i,
   .enh_en_i, .tx_wr_i, .rx_clear_o, .ctrl_o, .tx_level_o, .tx_space_o, .tx_full_o, .tx_empty_o,
   .tx_overflow_o, .tx_trig_o, .rx_trig_o, .tx_idle_o, .tx_o);

// ### utf_line_rx.sv
`timescale 1ns/1ps
module utf_line_rx
#(
   parameter int BITC = 64
)
(
   // Clock and serial line
   input  wire logic ref_clk_i,
   input  wire logic line_i,
   // Received bytes
   output logic [7:0] byte_o [8],
   output int         n_o
);
   logic [7:0] b;

   initial n_o = 0;
   always
   begin
      @(negedge line_i);
      repeat (BITC / 2) @(posedge ref_clk_i);
      for (int k = 0; k < 8; k++)
      begin
         repeat (BITC) @(posedge ref_clk_i);
         b[k] = line_i;
      end
      repeat (BITC) @(posedge ref_clk_i);
      if (line_i === 1'b1 && n_o < 8)
      begin
         byte_o[n_o] = b;
         n_o++;
      end
   end
endmodule // utf_line_rx

// ### test_uart_tx_fifo_control.sv
`timescale 1ns/1ps
module test_uart_tx_fifo_control;
   import utf_pkg::*;
   logic        ref_clk_i, rst_i, ctrl_wr_i, enh_en_i, tx_wr_i;
   logic [7:0]  ctrl_wdata_i, tx_wdata_i, rx_b [8];
   logic [6:0]  rx_level_i, tx_level_o, tx_space_o;
   logic [15:0] bit_cycles_i;
   logic        rx_clear_o, tx_full_o, tx_overflow_o, tx_trig_o, rx_trig_o, tx_idle_o, tx_o;
   logic        tx_empty_o;
   utf_ctrl_t   ctrl_o;
   int          err_count, n_checks, rx_n, i;
   int          rxt [4] = '{8, 16, 56, 60};

   utf_tx_fifo_ctrl dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ctrl_wr_i(ctrl_wr_i),
      .ctrl_wdata_i(ctrl_wdata_i), .enh_en_i(enh_en_i), .tx_wr_i(tx_wr_i), .tx_wdata_i(tx_wdata_i),
      .rx_level_i(rx_level_i), .rx_clear_o(rx_clear_o), .ctrl_o(ctrl_o), .tx_level_o(tx_level_o),
      .tx_space_o(tx_space_o), .tx_full_o(tx_full_o), .tx_empty_o(tx_empty_o),
      .tx_overflow_o(tx_overflow_o),
      .tx_trig_o(tx_trig_o), .rx_trig_o(rx_trig_o), .tx_idle_o(tx_idle_o),
      .bit_cycles_i(bit_cycles_i), .tx_o(tx_o));
   utf_line_rx #(.BITC(64)) line_u (.ref_clk_i(ref_clk_i), .line_i(tx_o), .byte_o(rx_b), .n_o(rx_n));

   always #5 ref_clk_i = ~ref_clk_i;

   task automatic chk_v(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_b(input logic g, input logic e);
      chk_v({7'h00, g}, {7'h00, e});
   endtask
   task automatic ctrl_wr(input logic [7:0] d);
      @(negedge ref_clk_i) ctrl_wr_i = 1'b1;
      ctrl_wdata_i = d;
      @(negedge ref_clk_i) ctrl_wr_i = 1'b0;
   endtask
   task automatic tx_burst(input int n, input logic [7:0] b);
      for (int k = 0; k < n; k++)
      begin
         @(negedge ref_clk_i) tx_wr_i = 1'b1;
         tx_wdata_i = 8'(b + k);
      end
      @(negedge ref_clk_i) tx_wr_i = 1'b0;
   endtask
   task automatic wait_idle();
      int k;
      for (k = 0; k < 20000 && tx_idle_o !== 1'b1; k++) @(negedge ref_clk_i);
      chk_b(k < 20000, 1'b1);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      err_count++;
      end_sim();
   end

   initial
   begin
      {ref_clk_i, ctrl_wr_i, enh_en_i, tx_wr_i, ctrl_wdata_i, tx_wdata_i, rx_level_i} = '0;
      rst_i = 1'b1;
      bit_cycles_i = 16'h0040;
      repeat (16) @(negedge ref_clk_i);
      rst_i = 1'b0;
      @(negedge ref_clk_i);
      chk_v({1'b0, ctrl_o}, 8'h00);
      chk_b(tx_o, 1'b1);
      chk_b(tx_empty_o, 1'b1);
      chk_v({1'b0, tx_space_o}, 8'h40);
      $display("test reset done");
      tx_burst(3, 8'hA5);
      wait_idle();
      for (i = 0; i < 3; i++) chk_v(rx_b[i], 8'(8'hA5 + i));
      $display("test disabled path done");
      enh_en_i = 1'b1;
      for (i = 0; i < 4; i++)
      begin
         ctrl_wr({i[1:0], i[1:0], 4'h1});
         chk_v({6'h00, ctrl_o.rx_trig}, 8'(i));
         chk_v({6'h00, ctrl_o.tx_trig}, 8'(i));
         rx_level_i = 7'(rxt[i] - 1);
         repeat (2) @(negedge ref_clk_i);
         chk_b(rx_trig_o, 1'b0);
         chk_b(tx_trig_o, 1'b1);
         rx_level_i = 7'(rxt[i]);
         repeat (2) @(negedge ref_clk_i);
         chk_b(rx_trig_o, 1'b1);
      end
      enh_en_i = 1'b0;
      ctrl_wr(8'h01);
      repeat (2) @(negedge ref_clk_i);
      chk_v({6'h00, ctrl_o.tx_trig}, 8'h03);
      chk_b(tx_trig_o, 1'b0);
      $display("test triggers done");
      tx_burst(66, 8'h00);
      chk_b(tx_full_o, 1'b1);
      chk_v({1'b0, tx_level_o}, 8'h40);
      chk_v({1'b0, tx_space_o}, 8'h00);
      chk_b(tx_empty_o, 1'b0);
      chk_b(tx_overflow_o, 1'b1);
      ctrl_wr(8'h04);
      // Host keeps off the store for two clocks after a clear
      repeat (2) @(negedge ref_clk_i);
      chk_v({1'b0, tx_level_o}, 8'h00);
      chk_b(tx_empty_o, 1'b1);
      chk_b(ctrl_o.tx_clr, 1'b0);
      chk_b(tx_overflow_o, 1'b0);
      tx_burst(1, 8'h5A);
      wait_idle();
      chk_v(8'(rx_n), 8'h05);
      chk_v(rx_b[3], 8'h00);
      chk_v(rx_b[4], 8'h5A);
      $display("test overflow and clear done");
      ctrl_wr(8'h02);
      chk_b(rx_clear_o, 1'b1);
      repeat (2) @(negedge ref_clk_i);
      chk_b(rx_clear_o, 1'b0);
      chk_b(rx_trig_o, 1'b0);
      $display("test rx clear done");
      end_sim();
   end
endmodule // test_uart_tx_fifo_control
